/* File: common/cirm_pkg.sv */
// package for the controller information register map: codes, layout, types
package cirm_pkg;

	// ----------------------------------------------------------------
	// file numbers of the map
	// ----------------------------------------------------------------
	localparam logic [7:0] CIRM_FILE_INFO = 8'h12;
	localparam logic [7:0] CIRM_FILE_WIDE = 8'h13;
	localparam logic [7:0] CIRM_FILE_RSV_LO = 8'h14;
	localparam logic [7:0] CIRM_FILE_RSV_HI = 8'h2f;
	localparam logic [7:0] CIRM_FILE_SPL_LO = 8'h30;
	localparam logic [7:0] CIRM_FILE_SPL_HI = 8'h3f;
	localparam logic [7:0] CIRM_FILE_PLOT_LO = 8'h40;
	localparam logic [7:0] CIRM_FILES_PER_PLOT = 8'h18;

	// ----------------------------------------------------------------
	// element numbers inside the information file
	// ----------------------------------------------------------------
	localparam logic [7:0] CIRM_EL_BOOT_MD = 8'h60;
	localparam logic [7:0] CIRM_EL_BOOT_YR = 8'h61;
	localparam logic [7:0] CIRM_EL_LOAD_MD = 8'h62;
	localparam logic [7:0] CIRM_EL_LOAD_YR = 8'h63;
	localparam logic [7:0] CIRM_EL_CTRL_MD = 8'h64;
	localparam logic [7:0] CIRM_EL_CTRL_YR = 8'h65;
	localparam logic [7:0] CIRM_EL_RELEASE = 8'h66;
	localparam logic [7:0] CIRM_EL_FEATURE = 8'h67;

	// ----------------------------------------------------------------
	// release codes and feature bits
	// ----------------------------------------------------------------
	localparam logic [15:0] CIRM_REL_STANDARD = 16'h0000;
	localparam logic [15:0] CIRM_REL_BETA = 16'h0042;
	localparam logic [15:0] CIRM_REL_SUPERIMP = 16'h5349;
	localparam int CIRM_FEAT_SENSOR_BIT = 0;
	localparam int CIRM_FEAT_LOOP2MS_BIT = 1;

	// ----------------------------------------------------------------
	// sizes, reset values and latency
	// ----------------------------------------------------------------
	localparam int CIRM_AXES = 8;
	localparam int CIRM_NODE_MIN = 1;
	localparam int CIRM_NODE_MAX = 90;
	localparam logic [31:0] CIRM_RST_COUNTS = 32'h0000_0000;
	localparam logic [31:0] CIRM_RST_DATA = 32'h0000_0000;
	localparam int CIRM_READ_LATENCY = 2;

	typedef enum logic [1:0] {
		CIRM_RELEASE_STANDARD,
		CIRM_RELEASE_BETA,
		CIRM_RELEASE_SUPERIMP
	} cirm_release_t;

	// one register access from the messaging front end
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] file;
		logic [7:0] elem;
		logic [15:0] wdata;
	} cirm_req_t;

	// read answer; 16-bit files use the low half only
	typedef struct packed {
		logic valid;
		logic [31:0] data;
	} cirm_rsp_t;

	// one word for the spline engine
	typedef struct packed {
		logic valid;
		logic [11:0] index;
		logic [15:0] data;
	} cirm_spline_t;

	// plot memory fetch
	typedef struct packed {
		logic rd;
		logic [2:0] axis;
		logic [12:0] word;
	} cirm_plot_t;

endpackage : cirm_pkg

/* File: src/cirm_regmap.sv */
// register map slice: firmware info, wide counts, reserved, spline, plot
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - firmware month/day and year words per image
// - release code: zero, beta letter, or two-letter
// - feature bit one set for 2 ms loop
// - feature bit zero set when sensor io fitted
// - eight read-only 32-bit counts, low half matches
// - wide counts keep all bits past 16-bit range
// - reserved region reads zero, writes discarded
// - spline region write only, reads zero
// - spline writes forwarded as intervals and points
// - plot region read only, writes ignored
// - plot: eight contiguous blocks, ascending axis order
// - transfers are raw frames on one segment
// - unique node number 1 to 90 replaces address
module cirm_regmap import cirm_pkg::*; #(
	parameter logic [15:0] BOOT_MD = 16'h0101, // arbitrary
	parameter logic [15:0] BOOT_YR = 16'h0001, // arbitrary
	parameter logic [15:0] LOAD_MD = 16'h0101, // arbitrary
	parameter logic [15:0] LOAD_YR = 16'h0001, // arbitrary
	parameter logic [15:0] CTRL_MD = 16'h0101, // arbitrary
	parameter logic [15:0] CTRL_YR = 16'h0001, // arbitrary
	parameter cirm_release_t RELEASE = CIRM_RELEASE_STANDARD,
	parameter int NODE_NUMBER = 1 // arbitrary
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// register access
	input wire cirm_req_t req_in,
	output cirm_rsp_t rsp_out,
	// straps from the board
	input wire logic loop_2ms_in,
	input wire logic sensor_discrete_io_in,
	// counts from the control loop
	input wire logic [CIRM_AXES-1:0][31:0] counts_in,
	input wire logic counts_update_in,
	// spline engine
	output cirm_spline_t spline_out,
	// plot memory
	output cirm_plot_t plot_out,
	input wire logic [15:0] plot_data_in,
	// network identity
	output logic [6:0] network_node_number_out
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// the raw-frame front end can only address nodes in this range
	if (NODE_NUMBER < CIRM_NODE_MIN ||
		NODE_NUMBER > CIRM_NODE_MAX) begin : g_bad_node
		$error("node number outside 1 to 90");
	end

	// the node number output is seven bits wide
	if (CIRM_NODE_MAX > 127) begin : g_bad_node_width
		$error("node number does not fit seven bits");
	end

	// the axis field and the wide-count decode are three bits wide
	if (CIRM_AXES != 8) begin : g_bad_axes
		$error("decode assumes eight axes");
	end

	// the read pipeline below has exactly two register stages
	if (CIRM_READ_LATENCY != 2) begin : g_bad_latency
		$error("read pipeline has two stages");
	end

	// the spline index carries four bits of file number
	if (int'(CIRM_FILE_SPL_HI) - int'(CIRM_FILE_SPL_LO) != 15) begin : g_bad_spl
		$error("spline area must span sixteen files");
	end

	// the plot word carries five bits of file offset inside a block
	if (int'(CIRM_FILES_PER_PLOT) > 32) begin : g_bad_plot_len
		$error("plot block longer than thirty-two files");
	end

	// blocks sit back to back and must end at the top file number
	if (int'(CIRM_FILE_PLOT_LO) + CIRM_AXES * int'(CIRM_FILES_PER_PLOT) !=
		256) begin : g_bad_plot_end
		$error("plot blocks do not fill the file range");
	end

	// regions are told apart by range compares and must not overlap
	if (CIRM_FILE_WIDE >= CIRM_FILE_RSV_LO ||
		CIRM_FILE_RSV_HI >= CIRM_FILE_SPL_LO ||
		CIRM_FILE_SPL_HI >= CIRM_FILE_PLOT_LO) begin : g_bad_regions
		$error("file regions overlap");
	end

	// both feature bits must be distinct and in the low half
	if (CIRM_FEAT_SENSOR_BIT == CIRM_FEAT_LOOP2MS_BIT ||
		CIRM_FEAT_SENSOR_BIT > 15 || CIRM_FEAT_LOOP2MS_BIT > 15) begin : g_bad_feat
		$error("feature bits collide or do not fit");
	end

	// a release code of zero would read as a standard build
	if (CIRM_REL_BETA == CIRM_REL_STANDARD ||
		CIRM_REL_SUPERIMP == CIRM_REL_STANDARD) begin : g_bad_release
		$error("special release codes must be nonzero");
	end

	// the eight information words sit at consecutive elements
	if (CIRM_EL_FEATURE - CIRM_EL_BOOT_MD != 8'h07) begin : g_bad_info
		$error("information words not consecutive");
	end

	// ----------------------------------------------------------------
	// strap synchronisers
	// ----------------------------------------------------------------
	// straps are board pins and may change at any time
	logic [1:0] strap_meta_q, strap_meta_d;
	logic [1:0] strap_q, strap_d;

	always_comb begin
		strap_meta_d = {loop_2ms_in, sensor_discrete_io_in};
		strap_d = strap_meta_q;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			strap_meta_q <= 2'h0;
			strap_q <= 2'h0;
		end else begin
			strap_meta_q <= strap_meta_d;
			strap_q <= strap_d;
		end
	end

	// ----------------------------------------------------------------
	// count snapshots
	// ----------------------------------------------------------------
	// whole words are captured at once so a read never mixes halves
	logic [CIRM_AXES-1:0][31:0] counts_q, counts_d;

	always_comb begin
		counts_d = counts_q;
		if (counts_update_in) begin
			counts_d = counts_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			counts_q <= {CIRM_AXES{CIRM_RST_COUNTS}};
		end else begin
			counts_q <= counts_d;
		end
	end

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// the build flavour is fixed when the block is built
	function automatic logic [15:0] release_code(input cirm_release_t r);
		case (r)
			CIRM_RELEASE_BETA: release_code = CIRM_REL_BETA;
			CIRM_RELEASE_SUPERIMP: release_code = CIRM_REL_SUPERIMP;
			default: release_code = CIRM_REL_STANDARD;
		endcase
	endfunction : release_code

	// plot blocks sit back to back from the first plot file upward
	function automatic cirm_plot_t plot_locate(input logic [7:0] file,
		input logic [7:0] elem);
		logic [7:0] rel;
		logic [7:0] base;
		cirm_plot_t p;
		rel = file - CIRM_FILE_PLOT_LO;
		p = '0;
		for (int a = 0; a < CIRM_AXES; a++) begin
			base = 8'(a * CIRM_FILES_PER_PLOT);
			if (rel >= base && rel < 8'(base + CIRM_FILES_PER_PLOT)) begin
				p.axis = 3'(a);
				p.word = {5'(rel - base), elem};
			end
		end
		return p;
	endfunction : plot_locate

	logic in_info, in_wide, in_rsv, in_spl, in_plot;

	always_comb begin
		in_info = req_in.file == CIRM_FILE_INFO;
		// wide counts answer only for axes that exist
		in_wide = req_in.file == CIRM_FILE_WIDE &&
			req_in.elem < 8'(CIRM_AXES);
		in_rsv = req_in.file >= CIRM_FILE_RSV_LO &&
			req_in.file <= CIRM_FILE_RSV_HI;
		in_spl = req_in.file >= CIRM_FILE_SPL_LO &&
			req_in.file <= CIRM_FILE_SPL_HI;
		// every file from the first plot file to the top is plot data
		in_plot = req_in.file >= CIRM_FILE_PLOT_LO;
	end

	// ----------------------------------------------------------------
	// read pipeline: stage one picks the word, stage two answers
	// ----------------------------------------------------------------
	// plot memory gets a full cycle, so every read answers on the
	// second edge after it is taken
	logic s1_valid_q, s1_valid_d;
	logic s1_plot_q, s1_plot_d;
	logic [31:0] s1_data_q, s1_data_d;
	cirm_plot_t plot_q, plot_d;
	cirm_rsp_t rsp_q, rsp_d;

	always_comb begin
		s1_valid_d = req_in.rd;
		s1_plot_d = 1'b0;
		s1_data_d = CIRM_RST_DATA;
		plot_d = '0;
		if (req_in.rd) begin
			if (in_info) begin
				case (req_in.elem)
					CIRM_EL_BOOT_MD: s1_data_d[15:0] = BOOT_MD;
					CIRM_EL_BOOT_YR: s1_data_d[15:0] = BOOT_YR;
					CIRM_EL_LOAD_MD: s1_data_d[15:0] = LOAD_MD;
					CIRM_EL_LOAD_YR: s1_data_d[15:0] = LOAD_YR;
					CIRM_EL_CTRL_MD: s1_data_d[15:0] = CTRL_MD;
					CIRM_EL_CTRL_YR: s1_data_d[15:0] = CTRL_YR;
					CIRM_EL_RELEASE: s1_data_d[15:0] = release_code(RELEASE);
					CIRM_EL_FEATURE: begin
						s1_data_d[CIRM_FEAT_LOOP2MS_BIT] = strap_q[1];
						s1_data_d[CIRM_FEAT_SENSOR_BIT] = strap_q[0];
					end
					default: s1_data_d = CIRM_RST_DATA;
				endcase
			end else if (in_wide) begin
				s1_data_d = counts_q[req_in.elem[2:0]];
			end else if (in_rsv || in_spl) begin
				// unused and write-only space still answers, with zero
				s1_data_d = CIRM_RST_DATA;
			end else if (in_plot) begin
				s1_plot_d = 1'b1;
				plot_d = plot_locate(req_in.file, req_in.elem);
				plot_d.rd = 1'b1;
			end
		end
		rsp_d.valid = s1_valid_q;
		rsp_d.data = s1_plot_q ? {16'h0000, plot_data_in} : s1_data_q;
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s1_valid_q <= 1'b0;
			s1_plot_q <= 1'b0;
			s1_data_q <= CIRM_RST_DATA;
			plot_q <= '0;
			rsp_q <= '0;
		end else begin
			s1_valid_q <= s1_valid_d;
			s1_plot_q <= s1_plot_d;
			s1_data_q <= s1_data_d;
			plot_q <= plot_d;
			rsp_q <= rsp_d;
		end
	end

	// ----------------------------------------------------------------
	// writes: only the spline area takes them
	// ----------------------------------------------------------------
	// reserved, plot, info and wide-count writes simply drop
	// a read in the same cycle shares no state with the write
	cirm_spline_t spline_q, spline_d;

	always_comb begin
		spline_d = '0;
		if (req_in.wr && in_spl) begin
			spline_d.valid = 1'b1;
			spline_d.index = {4'(req_in.file - CIRM_FILE_SPL_LO), req_in.elem};
			spline_d.data = req_in.wdata;
		end
		// in_rsv and in_plot writes produce nothing
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			spline_q <= '0;
		end else begin
			spline_q <= spline_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// all outputs leave from flops except the fixed node number
	always_comb begin
		rsp_out = rsp_q;
		plot_out = plot_q;
		spline_out = spline_q;
		// identity used by the raw-frame front end
		network_node_number_out = 7'(NODE_NUMBER);
	end

endmodule : cirm_regmap
`default_nettype wire

/* File: testbench/cirm_regmap_checker.sv */
// assertion checker for the register map slice
`timescale 1ns/1ps
`default_nettype none
module cirm_regmap_checker import cirm_pkg::*; (
	// watched ports
	input wire logic clk_in,
	input wire logic srst_in,
	input wire cirm_req_t req_in,
	input wire cirm_rsp_t rsp_out,
	input wire logic [CIRM_AXES-1:0][31:0] counts_in,
	input wire logic counts_update_in,
	input wire cirm_spline_t spline_out,
	input wire cirm_plot_t plot_out,
	input wire logic [15:0] plot_data_in,
	input wire logic [6:0] network_node_number_out
);
	// ----------------------------------------
	// shadow snapshots and plot address split
	// ----------------------------------------
	logic [CIRM_AXES-1:0][31:0] snap_q, snap_d;
	logic [31:0] pick_q, pick_d;
	logic [7:0] poff, pax, pfl;
	assign poff = req_in.file - CIRM_FILE_PLOT_LO;
	assign pax = poff / CIRM_FILES_PER_PLOT;
	assign pfl = poff % CIRM_FILES_PER_PLOT;
	always_comb begin
		snap_d = counts_update_in ? counts_in : snap_q;
		pick_d = snap_q[req_in.elem[2:0]];
	end
	always_ff @(posedge clk_in) begin
		snap_q <= srst_in ? '0 : snap_d;
		pick_q <= pick_d;
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	logic node_ok;
	assign node_ok = int'(network_node_number_out) inside
		{[CIRM_NODE_MIN:CIRM_NODE_MAX]};
	sequence s_spl_wr;
		req_in.wr && req_in.file inside {[CIRM_FILE_SPL_LO:CIRM_FILE_SPL_HI]};
	endsequence
	sequence s_plot_rd;
		req_in.rd && req_in.file >= CIRM_FILE_PLOT_LO;
	endsequence
	sequence s_rsv_rd;
		req_in.rd && req_in.file inside {[CIRM_FILE_RSV_LO:CIRM_FILE_RSV_HI]};
	endsequence
	sequence s_spl_rd;
		req_in.rd && req_in.file inside {[CIRM_FILE_SPL_LO:CIRM_FILE_SPL_HI]};
	endsequence
	sequence s_info_rd;
		req_in.rd && req_in.file == CIRM_FILE_INFO;
	endsequence
	sequence s_wide_rd;
		req_in.rd && req_in.file == CIRM_FILE_WIDE && req_in.elem < 8'h08;
	endsequence
	a_read_latency: assert property (req_in.rd |-> ##2 rsp_out.valid)
		else $error("read answer missing");
	a_valid_cause: assert property (rsp_out.valid |-> $past(req_in.rd, 2))
		else $error("answer without read");
	a_rsv_zero: assert property (s_rsv_rd |-> ##2 rsp_out.data == 32'h0)
		else $error("reserved read not zero");
	a_spl_rd_zero: assert property (s_spl_rd |-> ##2 rsp_out.data == 32'h0)
		else $error("spline read not zero");
	a_spl_fwd: assert property (s_spl_wr |=> spline_out.valid &&
		spline_out.index == {$past(req_in.file[3:0]), $past(req_in.elem)} &&
		spline_out.data == $past(req_in.wdata)) else $error("spline word wrong");
	a_spl_cause: assert property (spline_out.valid |->
		$past(req_in.wr) && $past(req_in.file) inside
		{[CIRM_FILE_SPL_LO:CIRM_FILE_SPL_HI]})
		else $error("spline word without spline write");
	a_plot_fetch: assert property (s_plot_rd |=> plot_out.rd &&
		plot_out.axis == $past(pax[2:0]) && plot_out.word == {$past(pfl[4:0]),
		$past(req_in.elem)}) else $error("plot fetch wrong");
	a_plot_ret: assert property (plot_out.rd |=> rsp_out.valid &&
		rsp_out.data == {16'h0, $past(plot_data_in)}) else $error("plot data");
	a_plot_cause: assert property (plot_out.rd |-> $past(req_in.rd))
		else $error("plot fetch without read");
	a_info_high: assert property (s_info_rd |-> ##2
		rsp_out.data[31:16] == 16'h0) else $error("info upper half");
	a_wide_cnt: assert property (s_wide_rd |-> ##2
		rsp_out.data == $past(pick_q)) else $error("wide count wrong");
	a_node_range: assert property (node_ok)
		else $error("node number out of range");
endmodule : cirm_regmap_checker
bind cirm_regmap cirm_regmap_checker u_chk (.clk_in, .srst_in, .req_in,
	.rsp_out, .counts_in, .counts_update_in, .spline_out, .plot_out,
	.plot_data_in, .network_node_number_out);
`default_nettype wire

/* File: testbench/cirm_plot_mem.sv */
// plot memory model answering plot fetches
`timescale 1ns/1ps
`default_nettype none
module cirm_plot_mem import cirm_pkg::*; (
	input wire logic clk_in,
	input wire cirm_plot_t plot_in,
	output logic [15:0] data_out
);
	// ----------------------------------------
	// word = axis and word address; off-fetch it toggles so stale data fails
	// ----------------------------------------
	logic [15:0] last_q;
	assign data_out = plot_in.rd ? {plot_in.axis, plot_in.word} : ~last_q;
	always_ff @(posedge clk_in) begin
		last_q <= data_out;
	end
endmodule : cirm_plot_mem
`default_nettype wire

/* File: testbench/cirm_regmap_tb.sv */
// self-checking bench for the register map slice
`timescale 1ns/1ps
`default_nettype none
module cirm_regmap_tb import cirm_pkg::*;;
	logic clk = 1'b0, srst = 1'b1, loop = 1'b0, sens = 1'b0, upd = 1'b0;
	cirm_req_t req = '0;
	cirm_rsp_t rsp, rsp_si;
	cirm_spline_t spl;
	cirm_plot_t plot;
	logic [CIRM_AXES-1:0][31:0] counts = '0;
	logic [15:0] pdat, lf = 16'h0024;
	logic [6:0] node;
	logic [31:0] v, mcnt [8];
	logic [15:0] info [7] = '{16'h0101, 16'h0001, 16'h0101, 16'h0001,
		16'h0c1f, 16'h0001, 16'h0042};
	int err_count = 0, num_checks = 0, cyc = 0, e;
	int fl [8] = '{20, 47, 48, 63, 64, 87, 88, 255};
	always #2 clk = ~clk;
	cirm_regmap #(.CTRL_MD(16'h0c1f), .RELEASE(CIRM_RELEASE_BETA),
		.NODE_NUMBER(CIRM_NODE_MAX)) dut (
		.clk_in(clk), .srst_in(srst), .req_in(req), .rsp_out(rsp),
		.loop_2ms_in(loop), .sensor_discrete_io_in(sens),
		.counts_in(counts), .counts_update_in(upd), .spline_out(spl),
		.plot_out(plot), .plot_data_in(pdat), .network_node_number_out(node));
	// a second build covers the two-letter release code
	cirm_regmap #(.RELEASE(CIRM_RELEASE_SUPERIMP)) dut_si (
		.clk_in(clk), .srst_in(srst), .req_in(req), .rsp_out(rsp_si),
		.loop_2ms_in(loop), .sensor_discrete_io_in(sens),
		.counts_in(counts), .counts_update_in(upd), .spline_out(),
		.plot_out(), .plot_data_in(pdat), .network_node_number_out());
	cirm_plot_mem mem (.clk_in(clk), .plot_in(plot), .data_out(pdat));
	// ----------------------------------------
	// model, drivers and compare
	// ----------------------------------------
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd
	function automatic logic [31:0] model(int f, int e);
		int o;
		o = f - 64;
		if (f == 18 && e >= 96 && e < 103) return {16'h0, info[e - 96]};
		if (f == 18 && e == 103) return {30'h0, loop, sens};
		if (f == 19 && e < 8) return mcnt[e];
		if (f >= 64) return {16'h0, 3'(o / 24), 5'(o % 24), 8'(e)};
		return 32'h0;
	endfunction : model
	task automatic chk(input logic [32:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input int f, e);
		@(posedge clk) req <= '{1'b1, 1'b0, 8'(f), 8'(e), 16'h0};
		@(posedge clk) req <= '0;
		@(posedge clk) #1 chk(rsp, {1'b1, model(f, e)});
		if (f == 18 && e == 102) chk(rsp_si, {17'h10000, CIRM_REL_SUPERIMP});
	endtask : rd
	// single-word accesses keep each transfer within the word limit
	task automatic wr(input int f, e, input logic [15:0] d);
		logic s;
		s = f >= 48 && f < 64;
		@(posedge clk) req <= '{1'b0, 1'b1, 8'(f), 8'(e), d};
		@(posedge clk) req <= '0;
		#1 chk({4'h0, spl}, s ? {5'h01, 4'(f - 48), 8'(e), d} : 33'h0);
	endtask : wr
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			err_count++;
			conclude();
		end
	end
	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk) {loop, sens} <= 2'(k);
			repeat (4) @(posedge clk);
			rd(18, 103);
		end
		for (int i = 96; i < 103; i++) rd(18, i);
		for (int a = 0; a < 8; a++) begin
			v = (a == 0) ? 32'hffff_fffe : {rnd(), rnd()};
			@(posedge clk) counts[a] <= v;
			upd <= 1'b1;
			mcnt[a] = v;
			@(posedge clk) upd <= 1'b0;
			rd(19, a);
		end
		@(posedge clk) counts[3] <= 32'h0001_0000;
		upd <= 1'b1;
		req <= '{1'b1, 1'b0, 8'h13, 8'h03, 16'h0};
		@(posedge clk) req <= '0;
		upd <= 1'b0;
		@(posedge clk) #1 chk(rsp, {1'b1, mcnt[3]});
		mcnt[3] = 32'h0001_0000;
		rd(19, 3);
		rd(19, 8);
		rd(5, 0);
		chk({26'h0, node}, 33'(CIRM_NODE_MAX));
		foreach (fl[i]) begin
			e = rnd() % 256;
			wr(fl[i], e, rnd());
			rd(fl[i], e);
		end
		conclude();
	end
endmodule : cirm_regmap_tb
`default_nettype wire
